// file: logic/tcu_pkg.sv
// tcu_pkg: constants, register map, field layouts and types of the
// timing channel unit.
// assumes one 250 MHz clock and a plain word-wide register port.

`default_nettype none

package tcu_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int TCU_NCH = 16;
	localparam int TCU_NTMR = 2;
	localparam int TCU_TW = 16;
	localparam int TCU_AW = 8;
	localparam int TCU_DW = 32;
	localparam int TCU_NIRQ = 18;
	localparam int TCU_PREW = 8;

	// ----------------------------------------------------------------
	// register map, byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] TCU_OFS_TCFG0 = 8'h00;
	localparam logic [7:0] TCU_OFS_TCFG1 = 8'h04;
	localparam logic [7:0] TCU_OFS_RLD0 = 8'h08;
	localparam logic [7:0] TCU_OFS_RLD1 = 8'h0c;
	localparam logic [7:0] TCU_OFS_CNT0 = 8'h10;
	localparam logic [7:0] TCU_OFS_CNT1 = 8'h14;
	localparam logic [7:0] TCU_OFS_GCTL = 8'h18;
	localparam logic [7:0] TCU_OFS_ISTAT = 8'h1c;
	localparam logic [7:0] TCU_OFS_IMASK = 8'h20;
	// channel config at 0x40 + 4*n, channel value at 0x80 + 4*n
	localparam logic [1:0] TCU_RGN_CHCFG = 2'h1;
	localparam logic [1:0] TCU_RGN_CHVAL = 2'h2;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int TCU_GCTL_STAG_BIT = 0;
	localparam int TCU_ISTAT_TOVF_BIT = 16;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] TCU_SRC_PRE = 2'h0;
	localparam logic [1:0] TCU_SRC_AUX = 2'h1;
	localparam logic [1:0] TCU_SRC_EXTR = 2'h2;
	localparam logic [1:0] TCU_SRC_EXTB = 2'h3;

	localparam logic [3:0] TCU_M_OFF = 4'h0;
	localparam logic [3:0] TCU_M_CAPR = 4'h1;
	localparam logic [3:0] TCU_M_CAPF = 4'h2;
	localparam logic [3:0] TCU_M_CAPB = 4'h3;
	localparam logic [3:0] TCU_M_CMP0 = 4'h4;
	localparam logic [3:0] TCU_M_CMP1 = 4'h5;
	localparam logic [3:0] TCU_M_CMP4 = 4'h8;

	// ----------------------------------------------------------------
	// types: timer config {run, src, psel}, channel config {tsel, mode}
	// ----------------------------------------------------------------
	typedef struct packed {
		logic run;
		logic [1:0] src;
		logic [2:0] psel;
	} tcu_tcfg_t;

	typedef struct packed {
		logic tsel;
		logic [3:0] mode;
	} tcu_ccfg_t;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam tcu_tcfg_t TCU_RST_TCFG = 6'h00;
	localparam tcu_ccfg_t TCU_RST_CCFG = 5'h00;
	localparam logic [15:0] TCU_RST_RLD = 16'h0000;
	localparam logic [15:0] TCU_RST_CNT = 16'h0000;
	localparam logic [15:0] TCU_CNT_TOP = 16'hffff;
	localparam logic [17:0] TCU_RST_IRQ = 18'h00000;

endpackage

`default_nettype wire

// file: logic/tcu_timer.sv
// tcu_timer: one 16-bit up-counting time base with reload.
// assumes count sources are already in the mclk_i domain.

`timescale 1ns/10ps
`default_nettype none

module tcu_timer import tcu_pkg::*; (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// configuration
	input wire tcu_tcfg_t cfg_i,
	input wire logic [TCU_TW-1:0] reload_i,
	// software load
	input wire logic load_i,
	input wire logic [TCU_TW-1:0] load_val_i,
	// count sources
	input wire logic aux_ovf_i,
	input wire logic ext_rise_i,
	input wire logic ext_fall_i,
	// state
	output logic [TCU_TW-1:0] count_o,
	output logic ovf_o
);

	// ----------------------------------------------------------------
	// prescaler and source selection
	// ----------------------------------------------------------------
	logic [TCU_PREW-1:0] pre;
	wire logic [TCU_PREW-1:0] pre_mask;
	wire logic pre_tick;
	wire logic tick;
	wire logic run_tick;
	wire logic wrap;

	// divide by 2**psel, a one-cycle enable rather than a second clock
	assign pre_mask = (8'h01 << cfg_i.psel) - 8'h01;
	assign pre_tick = (pre & pre_mask) == pre_mask;
	assign tick = (cfg_i.src == TCU_SRC_PRE) ? pre_tick :
		(cfg_i.src == TCU_SRC_AUX) ? aux_ovf_i :
		(cfg_i.src == TCU_SRC_EXTR) ? ext_rise_i :
		(ext_rise_i | ext_fall_i);
	assign run_tick = cfg_i.run & tick;
	assign wrap = count_o == TCU_CNT_TOP;

	// ----------------------------------------------------------------
	// counter: software load wins over counting
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pre <= '0;
			count_o <= TCU_RST_CNT;
			ovf_o <= 1'b0;
		end else begin
			pre <= pre + 8'h01;
			ovf_o <= run_tick & wrap & ~load_i;
			if (load_i)
				count_o <= load_val_i;
			else if (run_tick)
				count_o <= wrap ? reload_i : count_o + 16'h0001;
		end
	end

endmodule // tcu_timer

`default_nettype wire

// file: logic/tcu_channel.sv
// tcu_channel: one capture/compare channel and its pin.
// assumes pin_i is already synchronised and slot_i gates evaluation.

`timescale 1ns/10ps
`default_nettype none

module tcu_channel import tcu_pkg::*; (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// configuration and software write
	input wire tcu_ccfg_t cfg_i,
	input wire logic val_we_i,
	input wire logic [TCU_TW-1:0] val_i,
	// time bases and slot enable
	input wire logic [TCU_TW-1:0] t0_i,
	input wire logic [TCU_TW-1:0] t1_i,
	input wire logic slot_i,
	// pin
	input wire logic pin_i,
	output logic pin_o,
	output logic pin_oe_o,
	// state
	output logic [TCU_TW-1:0] val_o,
	output logic evt_o
);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic pin_q;
	logic pend;
	logic eq_q;
	wire logic [TCU_TW-1:0] tval;
	wire logic rise;
	wire logic fall;
	wire logic is_cap;
	wire logic is_cmp;
	wire logic trig;
	wire logic cap_fire;
	wire logic eq;
	wire logic match;
	wire logic act;

	assign tval = cfg_i.tsel ? t1_i : t0_i;
	assign rise = pin_i & ~pin_q;
	assign fall = ~pin_i & pin_q;
	assign is_cap = (cfg_i.mode >= TCU_M_CAPR) && (cfg_i.mode <= TCU_M_CAPB);
	assign is_cmp = (cfg_i.mode >= TCU_M_CMP0) && (cfg_i.mode <= TCU_M_CMP4);
	assign trig = ((cfg_i.mode == TCU_M_CAPR) & rise) |
		((cfg_i.mode == TCU_M_CAPF) & fall) |
		((cfg_i.mode == TCU_M_CAPB) & (rise | fall));
	// an edge seen off-slot waits for the channel's slot
	assign cap_fire = slot_i & (pend | trig);
	assign eq = is_cmp & (tval == val_o);
	// only the first cycle of equality counts, so a slow timer
	// sitting on the value does not fire repeatedly
	assign match = slot_i & eq & ~eq_q;
	// reserved compare modes match but take no action
	assign act = match & ((cfg_i.mode == TCU_M_CMP0) |
		(cfg_i.mode == TCU_M_CMP1));

	// ----------------------------------------------------------------
	// state: capture beats a software write in the same cycle
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pin_q <= 1'b0;
			pend <= 1'b0;
			eq_q <= 1'b0;
			val_o <= TCU_RST_CNT;
			evt_o <= 1'b0;
			pin_o <= 1'b0;
			pin_oe_o <= 1'b0;
		end else begin
			pin_q <= pin_i;
			pend <= is_cap & (pend | trig) & ~slot_i;
			eq_q <= slot_i ? eq : eq_q;
			evt_o <= (is_cap & cap_fire) | act;
			pin_oe_o <= cfg_i.mode == TCU_M_CMP1;
			if (act & (cfg_i.mode == TCU_M_CMP1))
				pin_o <= ~pin_o;
			if (is_cap & cap_fire)
				val_o <= tval;
			else if (val_we_i)
				val_o <= val_i;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_CAPTURE_TIMER:
	assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(is_cap && cap_fire) |=> (val_o == $past(tval)) && evt_o)
	else $error("capture did not latch the allocated timer");

	AST_EDGE_SELECT:
	assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(cfg_i.mode == TCU_M_CAPR && !rise && !pend && slot_i) |=> !evt_o)
	else $error("rising-edge capture fired without a rising edge");

	AST_TOGGLE:
	assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(match && cfg_i.mode == TCU_M_CMP1) |=> (pin_o != $past(pin_o)))
	else $error("compare mode 1 match did not toggle the pin");

	AST_CMP_ACT:
	assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(cfg_i.mode == TCU_M_CMP0 && slot_i && eq && !eq_q) |=> evt_o)
	else $error("compare match raised no event");

endmodule // tcu_channel

`default_nettype wire

// file: logic/tcu_unit.sv
// tcu_unit: timing channel unit top, two time bases and sixteen
// capture/compare channels behind a word register port.
// assumes a 250 MHz mclk_i; pins and count inputs are asynchronous,
// the aux timer overflow pulse comes from logic on mclk_i.
//
// Local design decisions: the register offsets and the strobed register port.

`timescale 1ns/10ps
`default_nettype none

module tcu_unit import tcu_pkg::*; (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [TCU_AW-1:0] addr_i,
	input wire logic [TCU_DW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [TCU_DW-1:0] rdata_o,
	// channel pins
	input wire logic [TCU_NCH-1:0] ch_pin_i,
	output logic [TCU_NCH-1:0] ch_pin_o,
	output logic [TCU_NCH-1:0] ch_pin_oe_o,
	// count sources
	input wire logic [TCU_NTMR-1:0] ext_cnt_i,
	input wire logic aux_ovf_i,
	// interrupt
	output logic irq_o
);

	// ----------------------------------------------------------------
	// registers and internal state
	// ----------------------------------------------------------------
	tcu_tcfg_t tcfg [TCU_NTMR];
	logic [TCU_TW-1:0] rld [TCU_NTMR];
	tcu_ccfg_t ch_cfg [TCU_NCH];
	logic stag;
	logic [TCU_NIRQ-1:0] istat;
	logic [TCU_NIRQ-1:0] imask;
	logic [2:0] slot;
	logic [TCU_DW-1:0] rd_mux;

	// synchronisers
	logic [TCU_NCH-1:0] pin_s1;
	logic [TCU_NCH-1:0] pin_s2;
	logic [TCU_NTMR-1:0] ext_s1;
	logic [TCU_NTMR-1:0] ext_s2;
	logic [TCU_NTMR-1:0] ext_s3;

	// timer and channel outputs
	logic [TCU_TW-1:0] cnt [TCU_NTMR];
	logic [TCU_NTMR-1:0] tovf;
	logic [TCU_TW-1:0] ch_val [TCU_NCH];
	logic [TCU_NCH-1:0] ch_evt;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	wire logic aligned;
	wire logic [1:0] rgn;
	wire logic [3:0] ch_idx;
	wire logic wr_ok;
	wire logic hit_ccfg;
	wire logic hit_cval;
	wire logic wr_tcfg0;
	wire logic wr_tcfg1;
	wire logic wr_rld0;
	wire logic wr_rld1;
	wire logic wr_cnt0;
	wire logic wr_cnt1;
	wire logic wr_gctl;
	wire logic wr_istat;
	wire logic wr_imask;
	wire logic [TCU_NTMR-1:0] t_load;
	wire logic [TCU_NIRQ-1:0] irq_clr;
	wire logic [TCU_NIRQ-1:0] irq_set;
	wire logic [TCU_NIRQ-1:0] next_istat;

	// the low address bits must be zero; anything else is unmapped
	assign aligned = addr_i[1:0] == 2'h0;
	assign rgn = addr_i[7:6];
	assign ch_idx = addr_i[5:2];
	assign wr_ok = wr_i & aligned;
	assign hit_ccfg = aligned & (rgn == TCU_RGN_CHCFG);
	assign hit_cval = aligned & (rgn == TCU_RGN_CHVAL);
	assign wr_tcfg0 = wr_ok & (addr_i == TCU_OFS_TCFG0);
	assign wr_tcfg1 = wr_ok & (addr_i == TCU_OFS_TCFG1);
	assign wr_rld0 = wr_ok & (addr_i == TCU_OFS_RLD0);
	assign wr_rld1 = wr_ok & (addr_i == TCU_OFS_RLD1);
	assign wr_cnt0 = wr_ok & (addr_i == TCU_OFS_CNT0);
	assign wr_cnt1 = wr_ok & (addr_i == TCU_OFS_CNT1);
	assign wr_gctl = wr_ok & (addr_i == TCU_OFS_GCTL);
	assign wr_istat = wr_ok & (addr_i == TCU_OFS_ISTAT);
	assign wr_imask = wr_ok & (addr_i == TCU_OFS_IMASK);
	assign t_load = {wr_cnt1, wr_cnt0};

	// ----------------------------------------------------------------
	// interrupt status: write one to clear, a new event wins
	// ----------------------------------------------------------------
	assign irq_clr = wr_istat ? wdata_i[TCU_NIRQ-1:0] : TCU_RST_IRQ;
	assign irq_set = {tovf, ch_evt};
	assign next_istat = (istat & ~irq_clr) | irq_set;
	// level output, high while any unmasked flag stands
	assign irq_o = |(istat & imask);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	// pins and external count inputs pass two flops first
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else begin
			pin_s1 <= ch_pin_i;
			pin_s2 <= pin_s1;
		end
	end

	// third flop gives the edge detector its previous level
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ext_s1 <= '0;
			ext_s2 <= '0;
			ext_s3 <= '0;
		end else begin
			ext_s1 <= ext_cnt_i;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end

	// ----------------------------------------------------------------
	// global registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			tcfg[0] <= TCU_RST_TCFG;
			tcfg[1] <= TCU_RST_TCFG;
		end else begin
			if (wr_tcfg0)
				tcfg[0] <= tcu_tcfg_t'(wdata_i[5:0]);
			if (wr_tcfg1)
				tcfg[1] <= tcu_tcfg_t'(wdata_i[5:0]);
		end
	end

	// reload values take effect at the next overflow
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rld[0] <= TCU_RST_RLD;
			rld[1] <= TCU_RST_RLD;
		end else begin
			if (wr_rld0)
				rld[0] <= wdata_i[TCU_TW-1:0];
			if (wr_rld1)
				rld[1] <= wdata_i[TCU_TW-1:0];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			stag <= 1'b0;
			istat <= TCU_RST_IRQ;
			imask <= TCU_RST_IRQ;
		end else begin
			istat <= next_istat;
			if (wr_gctl)
				stag <= wdata_i[TCU_GCTL_STAG_BIT];
			if (wr_imask)
				imask <= wdata_i[TCU_NIRQ-1:0];
		end
	end

	// ----------------------------------------------------------------
	// stagger slot counter
	// ----------------------------------------------------------------
	// eight slots shared by sixteen channels trades resolution
	// for fewer simultaneous events
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i)
			slot <= 3'h0;
		else
			slot <= slot + 3'h1;
	end

	// ----------------------------------------------------------------
	// time bases
	// ----------------------------------------------------------------
	for (genvar t = 0; t < TCU_NTMR; t++) begin : g_tmr
		wire logic ext_rise;
		wire logic ext_fall;

		assign ext_rise = ext_s2[t] & ~ext_s3[t];
		assign ext_fall = ~ext_s2[t] & ext_s3[t];

		tcu_timer u_tmr (
			.mclk_i(mclk_i),
			.rst_n_i(rst_n_i),
			.cfg_i(tcfg[t]),
			.reload_i(rld[t]),
			.load_i(t_load[t]),
			.load_val_i(wdata_i[TCU_TW-1:0]),
			.aux_ovf_i(aux_ovf_i),
			.ext_rise_i(ext_rise),
			.ext_fall_i(ext_fall),
			.count_o(cnt[t]),
			.ovf_o(tovf[t])
		);

		AST_RELOAD:
		assert property (@(posedge mclk_i) disable iff (!rst_n_i)
			tovf[t] |-> (cnt[t] == $past(rld[t])) &&
				($past(cnt[t]) == TCU_CNT_TOP))
		else $error("timer did not reload on overflow");

		AST_AUX_TICK:
		assert property (@(posedge mclk_i) disable iff (!rst_n_i)
			(tcfg[t].run && tcfg[t].src == TCU_SRC_AUX && aux_ovf_i &&
				!t_load[t] && cnt[t] != TCU_CNT_TOP)
			|=> cnt[t] == $past(cnt[t]) + 16'h0001)
		else $error("aux overflow did not advance the timer");

		AST_EXT_HOLD:
		assert property (@(posedge mclk_i) disable iff (!rst_n_i)
			(tcfg[t].run && tcfg[t].src == TCU_SRC_EXTR && !ext_rise &&
				!t_load[t]) |=> $stable(cnt[t]))
		else $error("timer moved without an external count edge");

		AST_STOPPED:
		assert property (@(posedge mclk_i) disable iff (!rst_n_i)
			(!tcfg[t].run && !t_load[t]) |=> $stable(cnt[t]) && !tovf[t])
		else $error("stopped timer changed");
	end

	// ----------------------------------------------------------------
	// channels
	// ----------------------------------------------------------------
	for (genvar i = 0; i < TCU_NCH; i++) begin : g_ch
		wire logic slot_en;
		wire logic val_we;

		// channel n acts in slot n mod 8 when staggered
		assign slot_en = ~stag | (slot == 3'(i));
		assign val_we = wr_ok & hit_cval & (ch_idx == 4'(i));

		always_ff @(posedge mclk_i) begin
			if (!rst_n_i)
				ch_cfg[i] <= TCU_RST_CCFG;
			else if (wr_ok & hit_ccfg & (ch_idx == 4'(i)))
				ch_cfg[i] <= tcu_ccfg_t'(wdata_i[4:0]);
		end

		tcu_channel u_ch (
			.mclk_i(mclk_i),
			.rst_n_i(rst_n_i),
			.cfg_i(ch_cfg[i]),
			.val_we_i(val_we),
			.val_i(wdata_i[TCU_TW-1:0]),
			.t0_i(cnt[0]),
			.t1_i(cnt[1]),
			.slot_i(slot_en),
			.pin_i(pin_s2[i]),
			.pin_o(ch_pin_o[i]),
			.pin_oe_o(ch_pin_oe_o[i]),
			.val_o(ch_val[i]),
			.evt_o(ch_evt[i])
		);

		AST_STAG_SLOT:
		assert property (@(posedge mclk_i) disable iff (!rst_n_i)
			(ch_evt[i] && $past(stag)) |-> $past(slot) == 3'(i))
		else $error("staggered channel acted outside its slot");

		AST_EVT_FLAG:
		assert property (@(posedge mclk_i) disable iff (!rst_n_i)
			ch_evt[i] |=> istat[i])
		else $error("channel event did not set its status flag");

		AST_CMP0_QUIET:
		assert property (@(posedge mclk_i) disable iff (!rst_n_i)
			(ch_cfg[i].mode == TCU_M_CMP0) |=> !ch_pin_oe_o[i])
		else $error("compare mode 0 drove the pin");

		AST_RSV_SILENT:
		assert property (@(posedge mclk_i) disable iff (!rst_n_i)
			(ch_cfg[i].mode > TCU_M_CMP1) |=> !ch_evt[i])
		else $error("reserved mode raised an event");
	end

	// ----------------------------------------------------------------
	// read path: data stand one cycle after the strobe, else zero
	// ----------------------------------------------------------------
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_ccfg)
			rd_mux = 32'(ch_cfg[ch_idx]);
		else if (hit_cval)
			rd_mux = 32'(ch_val[ch_idx]);
		else begin
			case (addr_i)
				TCU_OFS_TCFG0: rd_mux = 32'(tcfg[0]);
				TCU_OFS_TCFG1: rd_mux = 32'(tcfg[1]);
				TCU_OFS_RLD0: rd_mux = 32'(rld[0]);
				TCU_OFS_RLD1: rd_mux = 32'(rld[1]);
				TCU_OFS_CNT0: rd_mux = 32'(cnt[0]);
				TCU_OFS_CNT1: rd_mux = 32'(cnt[1]);
				TCU_OFS_GCTL: rd_mux = 32'(stag);
				TCU_OFS_ISTAT: rd_mux = 32'(istat);
				TCU_OFS_IMASK: rd_mux = 32'(imask);
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i)
			rdata_o <= 32'h0000_0000;
		else
			rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
	end

	AST_RD_ONE_CYCLE:
	assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!$past(rd_i) |-> rdata_o == 32'h0000_0000)
	else $error("read data outside the answer cycle");

endmodule // tcu_unit

`default_nettype wire

// file: sim/tcu_pin_model.sv
// tcu_pin_model: outside world on the channel pins of the timing unit.
// assumes the bench gives the level it wants; the block may drive back.

`timescale 1ns/10ps
`default_nettype none

module tcu_pin_model import tcu_pkg::*; (
	// level the outside source puts on each pin
	input wire logic [TCU_NCH-1:0] src_i,
	// block side of the pins
	input wire logic [TCU_NCH-1:0] pin_i,
	input wire logic [TCU_NCH-1:0] pin_oe_i,
	// resolved wire level, fed back to the block
	output logic [TCU_NCH-1:0] wire_o
);
	// a driven pin shows the block, so a source never fights it
	assign wire_o = (pin_oe_i & pin_i) | (~pin_oe_i & src_i);
endmodule // tcu_pin_model

`default_nettype wire

// file: sim/testbench.sv
// testbench: register port and pin scenarios for tcu_unit.
// assumes a 250 MHz clock; the bench drives count inputs and aux overflow.

`timescale 1ns/10ps
`default_nettype none

module testbench import tcu_pkg::*; ;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [TCU_AW-1:0] addr_i = '0;
	logic [TCU_DW-1:0] wdata_i = '0;
	logic [TCU_DW-1:0] rdata_o;
	logic [TCU_NCH-1:0] src = '0;
	logic [TCU_NTMR-1:0] ext_cnt = '0;
	logic aux_ovf = 1'b0;
	logic [TCU_NCH-1:0] pin_w;
	logic [TCU_NCH-1:0] ch_pin_o;
	logic [TCU_NCH-1:0] ch_pin_oe_o;
	logic irq_o;
	int n_errors = 0;
	int check_count = 0;

	// ------------------------------------------------------------
	// design and pin partner
	// ------------------------------------------------------------
	tcu_unit u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.ch_pin_i(pin_w), .ch_pin_o(ch_pin_o), .ch_pin_oe_o(ch_pin_oe_o),
		.ext_cnt_i(ext_cnt), .aux_ovf_i(aux_ovf), .irq_o(irq_o));
	tcu_pin_model u_pins (.src_i(src), .pin_i(ch_pin_o),
		.pin_oe_i(ch_pin_oe_o), .wire_o(pin_w));

	// clock, 4 ns period
	initial begin
		forever #2 mclk_i = ~mclk_i;
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe edge
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, exp);
	endtask

	// pin change, then enough cycles for sync, edge and flag
	task automatic pins(input logic [15:0] v);
		@(posedge mclk_i);
		src <= v;
		repeat (10) @(posedge mclk_i);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rchk(TCU_OFS_ISTAT, 32'h0000_0000);
		rchk(TCU_OFS_CNT0, 32'h0000_0000);
		rchk(8'hfc, 32'h0000_0000); // unmapped reads zero
		chk(32'(ch_pin_oe_o), 32'h0000_0000);
		chk(32'(irq_o), 32'h0000_0000);
		$display("test reset done");
	endtask

	// timers stopped, so captured values are exact
	task automatic t_capture();
		wreg(TCU_OFS_CNT0, 32'h0000_1234);
		wreg(TCU_OFS_CNT1, 32'h0000_0055);
		wreg(TCU_OFS_IMASK, 32'h0000_0001);
		wreg(8'h40, {27'h0, 1'b0, TCU_M_CAPR});
		wreg(8'h44, {27'h0, 1'b1, TCU_M_CAPF});
		wreg(8'h54, {27'h0, 1'b0, TCU_M_CAPB});
		pins(16'h0023);
		rchk(8'h80, 32'h0000_1234);
		rchk(8'h84, 32'h0000_0000);
		rchk(8'h94, 32'h0000_1234);
		rchk(TCU_OFS_ISTAT, 32'h0000_0021);
		chk(32'(irq_o), 32'h0000_0001);
		wreg(TCU_OFS_CNT0, 32'h0000_0777);
		pins(16'h0000);
		rchk(8'h84, 32'h0000_0055);
		rchk(8'h80, 32'h0000_1234);
		rchk(8'h94, 32'h0000_0777);
		rchk(TCU_OFS_ISTAT, 32'h0000_0023);
		wreg(TCU_OFS_ISTAT, 32'h0000_0023);
		rchk(TCU_OFS_ISTAT, 32'h0000_0000);
		chk(32'(irq_o), 32'h0000_0000);
		$display("test capture done");
	endtask

	// ch2 toggles, ch3 flags only, ch4 reserved mode stays silent
	task automatic t_compare();
		wreg(8'h48, {27'h0, 1'b0, TCU_M_CMP1});
		wreg(8'h4c, {27'h0, 1'b0, TCU_M_CMP0});
		wreg(8'h50, {27'h0, 1'b0, 4'h6});
		for (int a = 8'h88; a <= 8'h90; a += 4) begin
			wreg(8'(a), 32'h0000_0010);
		end
		for (int i = 1; i <= 2; i++) begin
			wreg(TCU_OFS_CNT0, 32'h0000_000c);
			wreg(TCU_OFS_TCFG0, 32'h0000_0020);
			repeat (20) @(posedge mclk_i);
			wreg(TCU_OFS_TCFG0, 32'h0000_0000);
			chk(32'(ch_pin_o[2]), 32'(i % 2));
			chk(32'(ch_pin_oe_o), 32'h0000_0004);
			rchk(TCU_OFS_ISTAT, 32'h0000_000c);
			wreg(TCU_OFS_ISTAT, 32'h0000_000c);
		end
		$display("test compare done");
	endtask

	// overflow reloads and flags the timer interrupt
	// six ticks from 0xfffe: wrap at the second, stop at 0x0104
	task automatic t_reload();
		wreg(TCU_OFS_RLD0, 32'h0000_0100);
		wreg(TCU_OFS_CNT0, 32'h0000_fffe);
		wreg(TCU_OFS_IMASK, 32'h0001_0000);
		wreg(TCU_OFS_TCFG0, 32'h0000_0020);
		repeat (4) @(posedge mclk_i);
		wreg(TCU_OFS_TCFG0, 32'h0000_0000);
		rchk(TCU_OFS_ISTAT, 32'h0001_0000);
		chk(32'(irq_o), 32'h0000_0001);
		rchk(TCU_OFS_CNT0, 32'h0000_0104);
		$display("test reload done");
	endtask

	// timer0 counts ext rises then aux pulses, timer1 both ext edges;
	// then a staggered capture on ch0 with both timers stopped
	task automatic t_sources();
		wreg(TCU_OFS_ISTAT, 32'h0001_0000);
		wreg(TCU_OFS_CNT0, 32'h0000_0000);
		wreg(TCU_OFS_CNT1, 32'h0000_0000);
		wreg(TCU_OFS_TCFG0, 32'h0000_0030);
		wreg(TCU_OFS_TCFG1, 32'h0000_0038);
		repeat (3) begin
			@(posedge mclk_i);
			ext_cnt <= 2'b11;
			repeat (4) @(posedge mclk_i);
			ext_cnt <= 2'b00;
			repeat (4) @(posedge mclk_i);
		end
		wreg(TCU_OFS_TCFG1, 32'h0000_0000);
		wreg(TCU_OFS_TCFG0, 32'h0000_0028);
		repeat (5) begin
			@(posedge mclk_i);
			aux_ovf <= 1'b1;
			@(posedge mclk_i);
			aux_ovf <= 1'b0;
		end
		wreg(TCU_OFS_TCFG0, 32'h0000_0000);
		rchk(TCU_OFS_CNT0, 32'h0000_0008);
		rchk(TCU_OFS_CNT1, 32'h0000_0006);
		wreg(TCU_OFS_GCTL, 32'h0000_0001);
		pins(16'h0001);
		rchk(8'h80, 32'h0000_0008);
		rchk(TCU_OFS_ISTAT, 32'h0000_0001);
		$display("test sources done");
	endtask

	// main sequence
	initial begin
		repeat (10) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_capture();
		t_compare();
		t_reload();
		t_sources();
		give_verdict();
	end

	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#20000;
		n_errors++;
		give_verdict();
	end
endmodule // testbench

`default_nettype wire
